// [hw/tpm_pkg.sv]
package tpm_pkg;
	localparam int SAMPLES = 16;
	localparam int AMP_W = 8;
	localparam logic [7:0] SHAPE0_RST = 8'h7b;
	localparam logic [7:0] SHAPE1_RST = 8'h03;
	localparam logic [7:0] SHAPE2_RST = 8'h40;
	localparam logic [7:0] AMP_HI_RST = 8'h38;
	localparam logic [7:0] AMP_LO_RST = 8'h00;
	localparam int AMP_HI_COUNT = 8;
	localparam int ZERO_LIMIT = 31;
	localparam int ZCNT_W = 6;
	localparam int OC_PULSES = 3;
	localparam int OCNT_W = 2;
	// internal shape used ahead of the build-out filter
	localparam logic [7:0] T1SHORT0 = 8'hd7;
	localparam logic [7:0] T1SHORT1 = 8'h22;
	localparam logic [7:0] T1SHORT2 = 8'h11;

	typedef enum logic [1:0] {ATT_0DB, ATT_7P5DB, ATT_15DB, ATT_22P5DB} tpm_att_t;

	typedef struct packed {
		logic [7:0] code0;
		logic [7:0] code1;
		logic [7:0] code2;
	} tpm_codes_t;

	typedef struct packed {
		logic onesDensity;
		logic highCurrent;
	} tpm_status_t;
endpackage

// [hw/tpm_sample_sel.sv]
`timescale 1ns/1ns
module tpm_sample_sel #(
	parameter int SAMPLES = 16,
	parameter int AMP_W = 8
) (
	input wire logic [SAMPLES*AMP_W-1:0] ampFlat,
	input wire logic [3:0] sampleIdx,
	output logic signed [AMP_W-1:0] ampOut
);
	logic signed [AMP_W-1:0] amps [SAMPLES];
	genvar g;
	generate
		for (g = 0; g < SAMPLES; g++) begin : gAmp
			assign amps[g] = ampFlat[g*AMP_W +: AMP_W];
		end
	endgenerate
	assign ampOut = amps[sampleIdx]; // R09
endmodule

// [hw/tpm_shaper_monitor.sv]
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// R01: reset selects legacy shape codes
// R02: legacy codes reset to 7b 03 40
// R03: software reprograms shape after T1 switch
// R04: legacy plus attenuation uses internal short shape
// R05: two-bit attenuation 0/7.5/15/22.5 dB
// R06: per-sample mode uses sixteen amplitude points
// R07: samples 1-8 reset 38, 9-16 zero
// R08: per-sample mode kept under attenuation
// R09: sample amplitudes are signed
// R10: software loads d7 22 11 T1 short
// R11: software loads 9c 03 00 E1 120
// R12: software loads T1 per-sample values
// R13: three overcurrent pulses tri-state unless disabled
// R14: release tri-state when current drops
// R15: flag more than 31 consecutive zeros
// R16: report overcurrent in status bit
// R17: status change raises interrupt pulse
module tpm_shaper_monitor #(
	parameter int SAMPLES = tpm_pkg::SAMPLES,
	parameter int AMP_W = tpm_pkg::AMP_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic shapeSourceSelect,
	input wire tpm_pkg::tpm_att_t buildOutAttenuation,
	input wire logic codeWe,
	input wire logic [1:0] codeIdx,
	input wire logic [7:0] codeWdata,
	input wire logic ampWe,
	input wire logic [3:0] ampIdx,
	input wire logic [AMP_W-1:0] ampWdata,
	input wire logic autoTristateDisable,
	input wire logic symStrobe,
	input wire logic txMark,
	input wire logic [3:0] sampleIdx,
	input wire logic overCurrentPin,
	output tpm_pkg::tpm_codes_t activeCodes,
	output tpm_pkg::tpm_codes_t legacyShapeCodes,
	output logic useSamples,
	output logic [1:0] attSelect,
	output logic signed [AMP_W-1:0] sampleAmp,
	output logic [SAMPLES*AMP_W-1:0] sampleAmplitudeRegs,
	output logic txLineOutEnable,
	output tpm_pkg::tpm_status_t lineStatusReg,
	output logic monitorIrq
);
	//////////////////////////////////////////////////////////////////////////////
	// shape registers
	logic [7:0] code0_q;
	logic [7:0] code1_q;
	logic [7:0] code2_q;
	tpm_pkg::tpm_codes_t storedCodes;
	logic [SAMPLES*AMP_W-1:0] amps_q;
	logic [7:0] srcSel_q;
	logic srcSel_d;
	logic code0Hit;
	logic code1Hit;
	logic code2Hit;
	assign srcSel_d = shapeSourceSelect;
	// index 3 has no register behind it, so a write there is dropped
	assign code0Hit = codeWe && (codeIdx == 2'h0);
	assign code1Hit = codeWe && (codeIdx == 2'h1);
	assign code2Hit = codeWe && (codeIdx == 2'h2);
	assign storedCodes = '{code0_q, code1_q, code2_q};

	always_ff @(posedge clk) begin
		if (srst) begin
			code0_q <= tpm_pkg::SHAPE0_RST; // R02
		end else if (code0Hit) begin
			code0_q <= codeWdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			code1_q <= tpm_pkg::SHAPE1_RST; // R02
		end else if (code1Hit) begin
			code1_q <= codeWdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			code2_q <= tpm_pkg::SHAPE2_RST; // R02
		end else if (code2Hit) begin
			code2_q <= codeWdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < SAMPLES; g++) begin : gAmpReg
			logic ampHit;
			assign ampHit = ampWe && (ampIdx == 4'(g));
			always_ff @(posedge clk) begin
				if (srst) begin
					amps_q[g*AMP_W +: AMP_W] <= (g < tpm_pkg::AMP_HI_COUNT) ?
						AMP_W'(tpm_pkg::AMP_HI_RST) : AMP_W'(tpm_pkg::AMP_LO_RST); // R07
				end else if (ampHit) begin
					amps_q[g*AMP_W +: AMP_W] <= ampWdata; // R06
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			srcSel_q <= 8'h00; // R01
		end else begin
			srcSel_q <= {7'h00, srcSel_d};
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// shape selection
	logic attOn;
	tpm_pkg::tpm_codes_t internalCodes;
	assign attOn = (buildOutAttenuation != tpm_pkg::ATT_0DB);
	assign internalCodes = '{tpm_pkg::T1SHORT0, tpm_pkg::T1SHORT1, tpm_pkg::T1SHORT2};
	assign useSamples = srcSel_q[0]; // R08
	assign attSelect = buildOutAttenuation; // R05
	assign legacyShapeCodes = storedCodes;
	assign sampleAmplitudeRegs = amps_q;
	assign activeCodes = attOn ? internalCodes : storedCodes; // R04

	tpm_sample_sel #(
		.SAMPLES(SAMPLES),
		.AMP_W(AMP_W)
	) uSel (
		.ampFlat(amps_q),
		.sampleIdx(sampleIdx),
		.ampOut(sampleAmp)
	);

	//////////////////////////////////////////////////////////////////////////////
	// line monitor; comparator is asynchronous to clk, so synchronise it
	logic ocMeta_q;
	logic ocSync_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			ocMeta_q <= 1'b0;
			ocSync_q <= 1'b0;
		end else begin
			ocMeta_q <= overCurrentPin;
			ocSync_q <= ocMeta_q;
		end
	end

	logic [tpm_pkg::ZCNT_W-1:0] zeroCnt_q;
	logic [tpm_pkg::ZCNT_W-1:0] zeroCnt_d;
	logic [tpm_pkg::OCNT_W-1:0] ocCnt_q;
	logic [tpm_pkg::OCNT_W-1:0] ocCnt_d;
	logic highCur_q;
	logic highCur_d;
	logic onesDen_q;
	logic onesDen_d;
	logic irq_q;
	logic irqSet;
	logic zeroSat;
	logic ocSat;

	// the zero count saturates above the limit so a long zero run holds the flag
	assign zeroSat = (zeroCnt_q > tpm_pkg::ZCNT_W'(tpm_pkg::ZERO_LIMIT));
	assign zeroCnt_d = !symStrobe ? zeroCnt_q :
		txMark ? '0 : (zeroSat ? zeroCnt_q : zeroCnt_q + 1'b1);
	assign onesDen_d = (zeroCnt_d > tpm_pkg::ZCNT_W'(tpm_pkg::ZERO_LIMIT)); // R15
	assign ocSat = (ocCnt_q == tpm_pkg::OCNT_W'(tpm_pkg::OC_PULSES));
	assign ocCnt_d = !ocSync_q ? '0 :
		(symStrobe && txMark && !ocSat) ? ocCnt_q + 1'b1 : ocCnt_q;
	// drops as soon as the synchronised comparator falls, two clocks after the pin falls
	assign highCur_d = ocSync_q && (ocCnt_d == tpm_pkg::OCNT_W'(tpm_pkg::OC_PULSES)); // R16
	// pulses in the cycle the status changes; there is no mask and no clear
	assign irqSet = (highCur_d != highCur_q) || (onesDen_d != onesDen_q); // R17

	always_ff @(posedge clk) begin
		if (srst) begin
			zeroCnt_q <= '0;
		end else begin
			zeroCnt_q <= zeroCnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ocCnt_q <= '0;
		end else begin
			ocCnt_q <= ocCnt_d; // R13
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			highCur_q <= 1'b0;
		end else begin
			highCur_q <= highCur_d; // R14
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			onesDen_q <= 1'b0;
		end else begin
			onesDen_q <= onesDen_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irqSet;
		end
	end

	assign txLineOutEnable = !(highCur_q && !autoTristateDisable); // R13
	assign lineStatusReg = '{onesDen_q, highCur_q};
	assign monitorIrq = irq_q;
endmodule

// [tb/tpm_line_model.sv]
`timescale 1ns/1ns
module tpm_line_model (
	input wire logic fault,
	input wire logic txLineOutEnable,
	output logic overCurrentPin
);
	// a released driver draws no current, so the comparator falls
	assign overCurrentPin = fault & txLineOutEnable;
endmodule

// [tb/tpm_shaper_monitor_asserts.sv]
`timescale 1ns/1ns
module tpm_shaper_monitor_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire logic shapeSourceSelect,
	input wire tpm_pkg::tpm_att_t buildOutAttenuation,
	input wire logic autoTristateDisable,
	input wire tpm_pkg::tpm_codes_t activeCodes,
	input wire tpm_pkg::tpm_codes_t legacyShapeCodes,
	input wire logic useSamples,
	input wire logic txLineOutEnable,
	input wire tpm_pkg::tpm_status_t lineStatusReg,
	input wire logic monitorIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_chg; lineStatusReg != $past(lineStatusReg); endsequence
	property p_sel; shapeSourceSelect |=> useSamples; endproperty
	property p_int; |buildOutAttenuation |-> activeCodes == 24'hd72211; endproperty
	property p_reg; buildOutAttenuation == 2'h0 |-> activeCodes == legacyShapeCodes; endproperty
	property p_dis; autoTristateDisable |-> txLineOutEnable; endproperty
	property p_tri; lineStatusReg.highCurrent && !autoTristateDisable |-> !txLineOutEnable; endproperty
	property p_rel; !txLineOutEnable |-> lineStatusReg.highCurrent; endproperty
	property p_irq; s_chg |-> monitorIrq; endproperty
	property p_irb; monitorIrq |-> s_chg; endproperty
	a_sel: assert property (p_sel) else $error("sel");
	a_int: assert property (p_int) else $error("int");
	a_reg: assert property (p_reg) else $error("reg");
	a_dis: assert property (p_dis) else $error("dis");
	a_tri: assert property (p_tri) else $error("tri");
	a_rel: assert property (p_rel) else $error("rel");
	a_irq: assert property (p_irq) else $error("irq");
	a_irb: assert property (p_irb) else $error("irb");
endmodule
bind tpm_shaper_monitor tpm_shaper_monitor_asserts i_chk (.*);

// [tb/tpm_shaper_monitor_bench.sv]
`timescale 1ns/1ns
module tpm_shaper_monitor_bench;
	logic clk = '0, srst = '1, codeWe = '0, ampWe = '0, fault = '0, txMark = '0;
	logic shapeSourceSelect = '0, autoTristateDisable = '0, symStrobe = '0;
	logic useSamples, txLineOutEnable, monitorIrq, overCurrentPin;
	logic [1:0] codeIdx = '0, attSelect;
	logic [3:0] ampIdx = '0, sampleIdx = 4'h9;
	logic [7:0] codeWdata = '0, ampWdata = '0, sampleAmp;
	logic [127:0] sampleAmplitudeRegs;
	tpm_pkg::tpm_att_t buildOutAttenuation = tpm_pkg::ATT_0DB;
	tpm_pkg::tpm_codes_t activeCodes, legacyShapeCodes;
	tpm_pkg::tpm_status_t lineStatusReg;
	int n_errors = 0, checks_done = 0, i;
	tpm_shaper_monitor i_tpm_shaper_monitor (.*);
	tpm_line_model i_tpm_line_model (.*);
	always #10 clk = ~clk;
	////////////////////////////////////////
	task tick; @(posedge clk) #2; endtask
	task chk(logic [127:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("Error %0t got %h", $time, g);
		end
	endtask
	// strobes back to back, then one idle cycle so the next call never collides
	task sym(logic m, int n);
		repeat (n) begin
			{symStrobe, txMark} = {1'h1, m};
			tick;
		end
		symStrobe = '0;
		tick;
	endtask
	task wrcode(logic [1:0] a, logic [7:0] d);
		{codeWe, codeIdx, codeWdata} = {1'h1, a, d};
		tick;
		codeWe = '0;
		tick;
	endtask
	task wramp(logic [3:0] a, logic [7:0] d);
		{ampWe, ampIdx, ampWdata} = {1'h1, a, d};
		tick;
		ampWe = '0;
		tick;
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (5) tick;
		srst = '0;
		chk(legacyShapeCodes, 24'h7b0340);
		chk(useSamples, '0);
		chk(sampleAmplitudeRegs, {{8{8'h00}}, {8{8'h38}}});
		// index 3 carries junk that must be dropped
		for (i = 0; i < 4; i++) begin
			{codeWe, codeIdx, codeWdata} = {1'h1, i[1:0], 8'(32'h9c0300ff >> (24 - 8 * i))};
			tick;
		end
		codeWe = '0;
		chk(activeCodes, 24'h9c0300);
		buildOutAttenuation = tpm_pkg::ATT_22P5DB;
		shapeSourceSelect = 1'h1;
		{ampWe, ampIdx, ampWdata} = {1'h1, 4'h9, 8'hef};
		tick;
		ampWe = '0;
		tick;
		chk(attSelect, 2'h3);
		chk(activeCodes, 24'hd72211);
		chk(useSamples, 1'h1);
		chk(sampleAmp, 8'hef);
		sym(1'h0, 31);
		chk(lineStatusReg, '0);
		{symStrobe, txMark} = 2'h2;
		tick;
		symStrobe = '0;
		chk(monitorIrq, 1'h1);
		chk(lineStatusReg, 2'h2);
		tick;
		chk(monitorIrq, '0);
		fault = 1'h1;
		repeat (3) tick;
		sym(1'h1, 3);
		chk(lineStatusReg, 2'h1);
		chk(txLineOutEnable, '0);
		for (i = 0; i < 20 && txLineOutEnable !== 1'h1; i++) tick;
		chk(i < 20, 1'h1);
		autoTristateDisable = 1'h1;
		repeat (3) tick;
		sym(1'h1, 3);
		chk({lineStatusReg, txLineOutEnable}, 3'h3);
		// T1 has no reset shape, so software loads one itself
		buildOutAttenuation = tpm_pkg::ATT_0DB;
		shapeSourceSelect = '0;
		wrcode(2'h0, 8'hd7);
		wrcode(2'h1, 8'h22);
		wrcode(2'h2, 8'h11);
		chk(legacyShapeCodes, 24'hd72211);
		chk(activeCodes, 24'hd72211);
		for (i = 0; i < 8; i++) wramp(4'(i), (i < 3) ? 8'h2e : 8'h2c);
		chk(sampleAmplitudeRegs, {48'h0, 8'hef, 8'h00, {5{8'h2c}}, {3{8'h2e}}});
		tally_and_finish;
	end
endmodule
